// >>> hdl/tspm_pkg.sv
// Shared constants and types for the set-point mode register block
// *****************************************************************
// What this block does
// - Address 0x0d control, 0x0e dq reference
// - Control bit 0 enters command bus training
// - Training with clock-enable low echoes address lines
// - Controller raises clock-enable before clearing training
// - Control bit 1 enables read preamble training
// - Reference output shows active set point only
// - Control bit 3 selects fast reference response
// - Refresh option needs capability bit set
// - Option zero reports 011b for 001b/010b
// - Controller follows reported refresh rate field; tspm_ctrl here does not read it
// - Mask disable set forbids masked writes
// - Bit 6 picks set point written
// - Bit 7 picks set point operating
// - Both selectors default to set point 0
// - Level code 0 to 50 only
// - Bit 6 range select, range 1 default
// - Read returns eight bits, bit 7 zero
// - Dq reference access follows write selector
// - Operate only from active set point copy
// - Range bit held until rewrite or reset
// - Controller writes range with level code
// *****************************************************************
package tspm_pkg;
    localparam logic [5:0] TSPM_ADDR_CTRL    = 6'h0d;
    localparam logic [5:0] TSPM_ADDR_DQREF   = 6'h0e;
    localparam int         TSPM_BIT_TRAIN    = 0;
    localparam int         TSPM_BIT_PREAMBLE = 1;
    localparam int         TSPM_BIT_REFOUT   = 2;
    localparam int         TSPM_BIT_FASTREF  = 3;
    localparam int         TSPM_BIT_RATEOPT  = 4;
    localparam int         TSPM_BIT_MASKDIS  = 5;
    localparam int         TSPM_BIT_WRSEL    = 6;
    localparam int         TSPM_BIT_OPSEL    = 7;
    localparam int         TSPM_BIT_RANGE    = 6;
    localparam logic [7:0] TSPM_CTRL_RESET   = 8'h00;
    localparam logic [7:0] TSPM_DQREF_RESET  = 8'h4d;
    localparam logic [5:0] TSPM_LEVEL_MAX    = 6'h32;
    localparam logic [2:0] TSPM_RATE_A       = 3'h1;
    localparam logic [2:0] TSPM_RATE_B       = 3'h2;
    localparam logic [2:0] TSPM_RATE_SUB     = 3'h3;
    // Controller register offsets on the Wishbone side
    localparam logic [3:0] TSPM_WB_CMD       = 4'h0;
    localparam logic [3:0] TSPM_WB_STATUS    = 4'h4;
    localparam logic [3:0] TSPM_WB_RDATA     = 4'h8;
    localparam logic [1:0] TSPM_OP_NONE      = 2'h0;
    localparam logic [1:0] TSPM_OP_MRW       = 2'h1;
    localparam logic [1:0] TSPM_OP_MRR       = 2'h2;
    localparam logic [1:0] TSPM_OP_MWR       = 2'h3;

    // Drop reserved level codes so they never reach the reference
    function automatic logic tspm_level_ok(input logic [7:0] v);
        return v[5:0] <= TSPM_LEVEL_MAX;
    endfunction : tspm_level_ok
endpackage : tspm_pkg

// >>> hdl/tspm_if.sv
// Command link between controller and mode register block
interface tspm_if;
    logic       cmd_valid;
    logic [1:0] cmd_op;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_data;
    logic       cke;
    logic [5:0] ca;
    logic       rd_valid;
    logic [7:0] dq;

    modport dev (input cmd_valid, cmd_op, cmd_addr, cmd_data, cke, ca,
                 output rd_valid, dq);
    modport ctl (output cmd_valid, cmd_op, cmd_addr, cmd_data, cke, ca,
                 input rd_valid, dq);
endinterface : tspm_if

// >>> hdl/tspm_device.sv
// Device end: control and dq reference mode registers
module tspm_device
    import tspm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    tspm_if.dev             link,
    input  wire logic       cap_rate_opt_i,
    input  wire logic [2:0] raw_rate_i,
    output logic            cmd_training_o,
    output logic            preamble_training_o,
    output logic            reference_output_o,
    output logic            fast_response_o,
    output logic            data_mask_disable_o,
    output logic            operating_sp_o,
    output logic [6:0]      active_dq_ref_o,
    output logic [2:0]      refresh_rate_o,
    output logic            masked_write_err_o
);
    import tspm_pkg::*;

    logic [7:0] ctrl_q;
    logic [6:0] dqref_q [2];
    logic       wsel;
    logic       wr_ctrl;
    logic       wr_dq;
    logic [2:0] rate_d;

    assign wsel    = ctrl_q[TSPM_BIT_WRSEL];
    assign wr_ctrl = link.cmd_valid && link.cmd_op == TSPM_OP_MRW
                     && link.cmd_addr == TSPM_ADDR_CTRL;
    assign wr_dq   = link.cmd_valid && link.cmd_op == TSPM_OP_MRW
                     && link.cmd_addr == TSPM_ADDR_DQREF;

    // Control register; training with clock-enable low blocks mode register writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_q <= TSPM_CTRL_RESET;
        else if (wr_ctrl && !(ctrl_q[TSPM_BIT_TRAIN] && !link.cke))
            ctrl_q <= link.cmd_data;
    end

    // Two set-point copies, written through the write selector
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dqref_q[0] <= TSPM_DQREF_RESET[6:0];
            dqref_q[1] <= TSPM_DQREF_RESET[6:0];
        end
        else if (wr_dq && !(ctrl_q[TSPM_BIT_TRAIN] && !link.cke)
                 && tspm_level_ok(link.cmd_data))
            dqref_q[wsel] <= link.cmd_data[6:0];
    end

    // Read path; training echo takes the bus while clock-enable is low
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link.rd_valid <= 1'b0;
            link.dq       <= 8'h00;
        end
        else if (ctrl_q[TSPM_BIT_TRAIN] && !link.cke)
        begin
            link.rd_valid <= 1'b1;
            link.dq       <= {2'b00, link.ca};
        end
        else if (link.cmd_valid && link.cmd_op == TSPM_OP_MRR
                 && link.cmd_addr == TSPM_ADDR_DQREF)
        begin
            link.rd_valid <= 1'b1;
            link.dq       <= {1'b0, dqref_q[wsel]};
        end
        else
        begin
            link.rd_valid <= 1'b0;
            link.dq       <= 8'h00;
        end
    end

    // Refresh report substitution
    always_comb
    begin
        rate_d = raw_rate_i;
        if (cap_rate_opt_i && !ctrl_q[TSPM_BIT_RATEOPT]
            && (raw_rate_i == TSPM_RATE_A || raw_rate_i == TSPM_RATE_B))
            rate_d = TSPM_RATE_SUB;
    end

    // Registered outputs for the rest of the device
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cmd_training_o      <= 1'b0;
            preamble_training_o <= 1'b0;
            reference_output_o  <= 1'b0;
            fast_response_o     <= 1'b0;
            data_mask_disable_o <= 1'b0;
            operating_sp_o      <= 1'b0;
            active_dq_ref_o     <= TSPM_DQREF_RESET[6:0];
            refresh_rate_o      <= 3'h0;
            masked_write_err_o  <= 1'b0;
        end
        else
        begin
            cmd_training_o      <= ctrl_q[TSPM_BIT_TRAIN];
            preamble_training_o <= ctrl_q[TSPM_BIT_PREAMBLE];
            reference_output_o  <= ctrl_q[TSPM_BIT_REFOUT];
            fast_response_o     <= ctrl_q[TSPM_BIT_FASTREF];
            data_mask_disable_o <= ctrl_q[TSPM_BIT_MASKDIS];
            operating_sp_o      <= ctrl_q[TSPM_BIT_OPSEL];
            active_dq_ref_o     <= dqref_q[ctrl_q[TSPM_BIT_OPSEL]];
            refresh_rate_o      <= rate_d;
            masked_write_err_o  <= link.cmd_valid && link.cmd_op == TSPM_OP_MWR
                                   && ctrl_q[TSPM_BIT_MASKDIS];
        end
    end
endmodule : tspm_device

// >>> hdl/tspm_ctrl.sv
// Controller end: Wishbone slave that issues mode register commands
module tspm_ctrl
    import tspm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    tspm_if.ctl              link
);
    import tspm_pkg::*;

    logic       go;
    logic       mask_dis_q;
    logic       rdv_q;
    logic [7:0] rd_q;
    logic       refused_q;

    assign go = cyc_i && stb_i && !ack_o;

    // Command register: [1:0] op, [13:8] addr, [23:16] data, [24] cke
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            link.cmd_valid <= 1'b0;
            link.cmd_op    <= TSPM_OP_NONE;
            link.cmd_addr  <= 6'h00;
            link.cmd_data  <= 8'h00;
            link.cke       <= 1'b1;
            link.ca        <= 6'h00;
            mask_dis_q     <= 1'b0;
            refused_q      <= 1'b0;
        end
        else
        begin
            link.cmd_valid <= 1'b0;
            if (go && we_i && adr_i == TSPM_WB_CMD && sel_i == 4'hf)
            begin
                link.cke <= dat_i[24];
                link.ca  <= dat_i[13:8];
                // Masked write is withheld while masking is disabled
                if (dat_i[1:0] == TSPM_OP_MWR && mask_dis_q)
                    refused_q <= 1'b1;
                // Clearing training needs clock-enable already high
                else if (dat_i[1:0] == TSPM_OP_MRW && dat_i[13:8] == TSPM_ADDR_CTRL
                         && !dat_i[16] && !link.cke)
                    refused_q <= 1'b1;
                // Range and level travel in one write; bad codes are refused
                else if (dat_i[1:0] == TSPM_OP_MRW && dat_i[13:8] == TSPM_ADDR_DQREF
                         && !tspm_level_ok(dat_i[23:16]))
                    refused_q <= 1'b1;
                else
                begin
                    refused_q      <= 1'b0;
                    link.cmd_valid <= dat_i[1:0] != TSPM_OP_NONE;
                    link.cmd_op    <= dat_i[1:0];
                    link.cmd_addr  <= dat_i[13:8];
                    link.cmd_data  <= dat_i[23:16];
                    if (dat_i[1:0] == TSPM_OP_MRW && dat_i[13:8] == TSPM_ADDR_CTRL)
                        mask_dis_q <= dat_i[16 + TSPM_BIT_MASKDIS];
                end
            end
        end
    end

    // Capture read data returned by the device
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdv_q <= 1'b0;
            rd_q  <= 8'h00;
        end
        else if (link.rd_valid)
        begin
            rdv_q <= 1'b1;
            rd_q  <= link.dq;
        end
        else if (go && !we_i && adr_i == TSPM_WB_RDATA)
            rdv_q <= 1'b0;
    end

    // Wishbone answer one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            ack_o <= go;
            dat_o <= 32'h0;
            if (go && !we_i)
                unique case (adr_i)
                    TSPM_WB_STATUS: dat_o <= {29'h0, refused_q, mask_dis_q, rdv_q};
                    TSPM_WB_RDATA:  dat_o <= {24'h0, rd_q};
                    default:        dat_o <= 32'h0;
                endcase
        end
    end
endmodule : tspm_ctrl

// >>> bench/tspm_chk.sv
// Link checker for the set-point mode register block
module tspm_chk
    import tspm_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [5:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic       cke,
    input wire logic [5:0] ca,
    input wire logic       rd_valid,
    input wire logic [7:0] dq
);
    logic trn_q;
    logic dmd_q;
    logic mrr_q;
    logic ign_w;
    logic ctl_w;
    logic mrr_w;
    // Training with clock-enable low makes the device deaf to mode register writes and reads
    assign ign_w = trn_q && !cke;
    assign ctl_w = cmd_valid && cmd_op == TSPM_OP_MRW && cmd_addr == TSPM_ADDR_CTRL && !ign_w;
    assign mrr_w = cmd_valid && cmd_op == TSPM_OP_MRR && !ign_w;
    // Shadows of the bits that shape legal traffic
    always_ff @(posedge clk_i)
    begin
        trn_q <= rst_i ? 1'b0 : (ctl_w ? cmd_data[0] : trn_q);
        dmd_q <= rst_i ? 1'b0 : (ctl_w ? cmd_data[5] : dmd_q);
        mrr_q <= rst_i ? 1'b0 : mrr_w;
    end
    // ****************
    // Link properties
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_mrr_reply: assert property (mrr_w && cmd_addr == TSPM_ADDR_DQREF |=> rd_valid && !dq[7])
        else $error("read of dq reference gave no clean answer");
    a_wo_silent: assert property (mrr_w && cmd_addr == TSPM_ADDR_CTRL && !trn_q |=> !rd_valid)
        else $error("control register answered a read");
    a_rd_cause: assert property (rd_valid |-> mrr_q || trn_q || $past(trn_q))
        else $error("read data without a cause");
    a_train_echo: assert property (ign_w ##1 ign_w |-> rd_valid && dq[7:6] == 2'h0)
        else $error("training echo missing");
    a_level_ok: assert property (cmd_valid && cmd_op == TSPM_OP_MRW
        && cmd_addr == TSPM_ADDR_DQREF |-> cmd_data[5:0] <= TSPM_LEVEL_MAX)
        else $error("reserved level code sent");
    a_cke_first: assert property (ctl_w && trn_q && !cmd_data[0] |-> cke)
        else $error("training cleared with clock-enable low");
    a_mask_legal: assert property (cmd_valid && cmd_op == TSPM_OP_MWR |-> !dmd_q)
        else $error("masked write while masking disabled");
    a_cmd_pulse: assert property ($rose(cmd_valid) |=> !cmd_valid)
        else $error("command held for two cycles");
    c_train: cover property (ign_w ##1 ign_w);
    c_mrr: cover property (rd_valid && !trn_q);
    c_opsel: cover property (ctl_w && cmd_data[7]);
endmodule : tspm_chk

// >>> bench/training_setpoint_mode_regs_bench.sv
// Self-checking bench for both ends of the set-point link
module training_setpoint_mode_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tspm_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cap = 1, ack;
    logic [3:0]  adr = 0, sel = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic [2:0]  raw = TSPM_RATE_A, rate;
    logic [7:0]  e;
    logic        trn, pre, reference_output, fast, data_mask_disable, osp, mwe;
    logic [6:0]  aref;
    int          miscompares = 0, cmp_count = 0;
    tspm_if link ();
    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;
    tspm_ctrl tspm_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .link(link.ctl));
    tspm_device tspm_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link.dev),
        .cap_rate_opt_i(cap),
        .raw_rate_i(raw), .cmd_training_o(trn), .preamble_training_o(pre),
        .reference_output_o(reference_output), .fast_response_o(fast), .data_mask_disable_o(data_mask_disable),
        .operating_sp_o(osp), .active_dq_ref_o(aref), .refresh_rate_o(rate),
        .masked_write_err_o(mwe));
    tspm_chk tspm_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid(link.cmd_valid),
        .cmd_op(link.cmd_op), .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data),
        .cke(link.cke), .ca(link.ca), .rd_valid(link.rd_valid), .dq(link.dq));
    // ****************
    // Shared tasks
    // ****************
    task final_report;
        $display("errors %0d in %0d checks", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One classic cycle; held until ack is sampled, bounded by a timeout
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        {cyc, stb, we, sel} <= {2'h3, w, 4'hf};
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        if (ack !== 1'b1)
        begin
            miscompares++;
            final_report();
        end
    endtask : wb
    task cmd(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d, input logic k);
        wb(1'b1, TSPM_WB_CMD, {7'h0, k, d, 2'h0, a, 6'h0, op});
    endtask : cmd
    // Register outputs trail the command by three edges
    task settle;
        repeat (3) @(posedge clk_i);
    endtask : settle
    task rd(input logic [5:0] a);
        cmd(TSPM_OP_MRR, a, 8'h0, 1'b1);
        repeat (2) @(posedge clk_i);
        wb(1'b0, TSPM_WB_RDATA, 32'h0);
    endtask : rd
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        settle;
        chk({osp, data_mask_disable, fast, reference_output, pre, trn}, 0, "ctrl");
        chk(aref, 7'h4d, "ref");
        chk(link.cke, 1, "cke");
        chk(rate, TSPM_RATE_SUB, "rate");
        for (int b = 1; b < 8; b++)
        begin
            e = 8'h1 << b;
            cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, e, 1'b1);
            settle;
            chk({osp, data_mask_disable, fast, reference_output, pre, trn}, {e[7], e[5], e[3:0]}, "ctrl");
            chk(mwe, 0, "mwe");
            chk(rate, e[4] ? TSPM_RATE_A : TSPM_RATE_SUB, "rate");
        end
        cap <= 1'b0;
        raw <= TSPM_RATE_B;
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h00, 1'b1);
        settle;
        chk(rate, TSPM_RATE_B, "rate");
        // Write set point 1 while set point 0 operates
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h40, 1'b1);
        cmd(TSPM_OP_MRW, TSPM_ADDR_DQREF, 8'h15, 1'b1);
        settle;
        chk(aref, 7'h4d, "ref");
        rd(TSPM_ADDR_DQREF);
        chk(q[7:0], 8'h15, "rd");
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h00, 1'b1);
        rd(TSPM_ADDR_DQREF);
        chk(q[7:0], 8'h4d, "rd");
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'hc0, 1'b1);
        settle;
        chk(aref, 7'h15, "ref");
        cmd(TSPM_OP_MRW, TSPM_ADDR_DQREF, 8'h73, 1'b1);
        wb(1'b0, TSPM_WB_STATUS, 32'h0);
        chk(q[2], 1, "refused");
        settle;
        chk(aref, 7'h15, "ref");
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h20, 1'b1);
        cmd(TSPM_OP_MWR, 6'h0, 8'h0, 1'b1);
        wb(1'b0, TSPM_WB_STATUS, 32'h0);
        chk(q[2:1], 2'h3, "mask");
        rd(TSPM_ADDR_CTRL);
        wb(1'b0, TSPM_WB_STATUS, 32'h0);
        chk(q[0], 0, "wo");
        // Training: echo of the address lines, then a clean exit
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h01, 1'b1);
        cmd(TSPM_OP_NONE, 6'h2a, 8'h0, 1'b0);
        settle;
        chk({link.rd_valid, link.dq}, 9'h12a, "echo");
        // Clearing training with clock-enable still low is withheld
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h00, 1'b0);
        wb(1'b0, TSPM_WB_STATUS, 32'h0);
        chk(q[2], 1, "cke");
        settle;
        chk(trn, 1, "trn");
        cmd(TSPM_OP_NONE, 6'h0, 8'h0, 1'b1);
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h00, 1'b1);
        settle;
        chk(trn, 0, "trn");
        // Reset in mid-run restores the set point 1 copy
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        cmd(TSPM_OP_MRW, TSPM_ADDR_CTRL, 8'h40, 1'b1);
        rd(TSPM_ADDR_DQREF);
        chk(q[7:0], 8'h4d, "rd");
        final_report();
    end
endmodule : training_setpoint_mode_regs_bench
